// *** hdl/acl_pkg.sv ***
// Shared constants and carriers for the ingress ACL evaluator.
// Assumes one 100 MHz core clock and a same-clock header parser.
package acl_pkg;
  // ****************************************
  // Sizes and timing
  // ****************************************
  localparam int NUM_RULES = 16;
  localparam int IDX_W     = 4;
  localparam int CNT_W     = 11;
  localparam int ADR_W     = 10;
  localparam int CLK_PERIOD_NS = 10;
  localparam int US_NS         = 1000;
  localparam int CYC_PER_US    = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int US_PER_MS     = 1000;
  localparam int US_CNT_W      = 7;
  localparam int MS_CNT_W      = 10;

  // ****************************************
  // Field encodings
  // ****************************************
  localparam logic [1:0] LAYER_OFF = 2'h0;
  localparam logic [1:0] LAYER_L2  = 2'h1;
  localparam logic [1:0] LAYER_L3  = 2'h2;
  localparam logic [1:0] LAYER_L4  = 2'h3;
  localparam logic [1:0] OPT_0     = 2'h0;
  localparam logic [1:0] OPT_1     = 2'h1;
  localparam logic [1:0] OPT_2     = 2'h2;
  localparam logic [1:0] OPT_3     = 2'h3;
  localparam logic [1:0] PC_OFF    = 2'h0;
  localparam logic [1:0] PC_EITHER = 2'h1;
  localparam logic [1:0] PC_INSIDE = 2'h2;
  localparam logic [1:0] PC_OUTSIDE = 2'h3;
  localparam logic       CA_WATCHDOG = 1'b0;
  localparam logic       TU_MS       = 1'b1;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [1:0] REGION_MATCH  = 2'h0;
  localparam logic [1:0] REGION_ACTION = 2'h1;
  localparam logic [1:0] REGION_PROC   = 2'h2;
  localparam logic [1:0] REGION_STAT   = 2'h3;
  localparam int REGION_LSB = 8;
  localparam int ENTRY_LSB  = 4;
  localparam int WORD_LSB   = 2;
  localparam logic [1:0] WORD_CTRL = 2'h0;
  localparam logic [1:0] WORD_VALA = 2'h1;
  localparam logic [1:0] WORD_VALB = 2'h2;
  localparam logic [31:0] CTRL_WR_MASK = 32'h0001_FFFF;
  localparam logic [31:0] ACT_WR_MASK  = 32'h00FF_1FFF;
  localparam logic [31:0] PROC_WR_MASK = 32'h000F_FFFF;
  localparam logic [IDX_W-1:0] STAT_ENTRY = 4'h0;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [14:0] rsvd;
    logic [7:0]  protocol;
    logic        flagEn;
    logic [1:0]  portCmp;
    logic        matchPolarity;
    logic        srcSel;
    logic [1:0]  matchOptionSel;
    logic [1:0]  matchLayerSel;
  } match_ctrl_t;

  typedef struct packed {
    logic [31:0] valB;
    logic [31:0] valA;
    match_ctrl_t ctrl;
  } match_rule_t;

  typedef struct packed {
    logic [7:0] rsvdHi;
    logic [7:0] fwdMap;
    logic [2:0] rsvdLo;
    logic       countAlgorithm;
    logic       countTimeUnit;
    logic [1:0] priorityModeField;
    logic [2:0] priorityValue;
    logic       remarkEnableField;
    logic [2:0] remarkValueField;
    logic [1:0] mapModeField;
  } action_rule_t;

  typedef struct packed {
    logic [11:0]      rsvd;
    logic [IDX_W-1:0] actionPointer;
    logic [15:0]      ruleSelectMask;
  } proc_entry_t;

  typedef struct packed {
    logic [47:0] dstMac;
    logic [47:0] srcMac;
    logic [15:0] etherType;
    logic        isIpv4;
    logic        isTcp;
    logic        isUdp;
    logic [31:0] srcIp;
    logic [31:0] dstIp;
    logic [7:0]  protocol;
    logic [15:0] srcPort;
    logic [15:0] dstPort;
    logic [31:0] tcpSeq;
    logic [7:0]  tcpFlags;
  } pkt_hdr_t;
endpackage

// *** hdl/acl_count_unit.sv ***
// Watchdog timer or event counter behind one count-mode matching rule.
// Assumes tick enables from the parent and a one-cycle hit pulse.
`timescale 1ns/10ps
module acl_count_unit
  import acl_pkg::*;
(
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  // Time base
  input  wire logic             usTick,
  input  wire logic             msTick,
  // Configuration
  input  wire logic             enable,
  input  wire logic             algorithm,
  input  wire logic             timeUnit,
  input  wire logic [CNT_W-1:0] countValue,
  // Events
  input  wire logic             hit,
  output logic                  expire
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic             armed;
    logic             expire;
  } cu_state_t;

  cu_state_t st_reg;
  cu_state_t st_next;

  always_comb
  begin
    logic tick;
    tick = (timeUnit == TU_MS) ? msTick : usTick;  // see [R13]
    st_next = st_reg;
    st_next.expire = 1'b0;
    if (!enable)
    begin
      st_next.cnt   = '0;
      st_next.armed = 1'b0;
    end
    else if (algorithm == CA_WATCHDOG)
    begin
      // Reload on every match so expiry measures the gap since the last one
      if (hit || !st_reg.armed)
      begin
        st_next.cnt   = countValue;  // see [R18]
        st_next.armed = 1'b1;
      end
      else if (tick)
      begin
        if (st_reg.cnt <= CNT_W'(1))
        begin
          st_next.expire = 1'b1;  // see [R14]
          st_next.cnt    = countValue;
        end
        else
          st_next.cnt = CNT_W'(st_reg.cnt - 1'b1);  // see [R14]
      end
    end
    else
    begin
      // Leaving watchdog mode starts the event count from zero
      if (st_reg.armed)
      begin
        st_next.cnt   = '0;
        st_next.armed = 1'b0;
      end
      else if (hit)
      begin
        if (CNT_W'(st_reg.cnt + 1'b1) >= countValue)
        begin
          st_next.expire = 1'b1;  // see [R15]
          st_next.cnt    = '0;
        end
        else
          st_next.cnt = CNT_W'(st_reg.cnt + 1'b1);  // see [R15]
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign expire = st_reg.expire;
endmodule

// *** hdl/acl_rule_evaluator.sv ***
// Per-port ingress ACL: rule tables, match evaluation, action choice.
// Assumes a same-clock parser pulsing pktValid with a stable header.
//
// What this block does
// [R1] Entry holds 4-bit pointer to one action
// [R2] Entry ANDs all rules picked by 16-bit mask
// [R3] One action per packet, lowest pointer wins
// [R4] Entries sharing an action OR their results
// [R5] Layer select 00 disables the matching rule
// [R6] Layer 2 options: count, type, MAC, both
// [R7] Layer 3 options: masked address, both addresses
// [R8] Layer 4 options: protocol, TCP, UDP, sequence
// [R9] Address select: 0 destination, 1 source
// [R10] Polarity: 0 mismatch true, 1 match true
// [R11] Layer 2 rule stores MAC and EtherType
// [R12] Count value is action's 11 low bits
// [R13] Time unit bit: 0 microsecond, 1 millisecond
// [R14] Watchdog counts down, interrupts on expiry
// [R15] Event counter counts matches, interrupts, resets
// [R16] Count rule gives no forwarding action
// [R17] All sixteen rules evaluated, index zero first
// [R18] Watchdog reloads on each qualifying packet
// [R19] Decision presented the cycle after header
//
// Design decisions made here: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
module acl_rule_evaluator
  import acl_pkg::*;
(
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst,
  // Wishbone slave
  input  wire logic [ADR_W-1:0]     wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic                 wb_we_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  output logic [31:0]               wb_dat_o,
  output logic                      wb_ack_o,
  // Header parser
  input  wire logic                 pktValid,
  input  pkt_hdr_t                  pktHdr,
  // Forwarding and QoS
  output logic                      decisionValid,
  output logic                      actionHit,
  output logic [IDX_W-1:0]          actionIndex,
  output action_rule_t              actionRule,
  // Count events
  output logic [NUM_RULES-1:0]      countIrq
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    match_rule_t  [NUM_RULES-1:0] mrule;
    action_rule_t [NUM_RULES-1:0] arule;
    proc_entry_t  [NUM_RULES-1:0] pent;
    logic                         ack;
    logic [31:0]                  rdata;
    logic                         decValid;
    logic                         hit;
    logic [IDX_W-1:0]             idx;
    action_rule_t                 act;
    logic [US_CNT_W-1:0]          usCnt;
    logic                         usTick;
    logic [MS_CNT_W-1:0]          msCnt;
    logic                         msTick;
    logic [NUM_RULES-1:0]         cntHit;
  } state_t;

  state_t st_reg;
  state_t st_next;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic [31:0] mergeBytes(
    input logic [31:0] old,
    input logic [31:0] wdat,
    input logic [3:0]  sel,
    input logic [31:0] wmask
  );
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        m[b*8 +: 8] = wdat[b*8 +: 8];
    return m & wmask;
  endfunction

  function automatic logic isCountRule(input match_rule_t r);
    return r.ctrl.matchLayerSel == LAYER_L2 && r.ctrl.matchOptionSel == OPT_0;
  endfunction

  function automatic logic evalRule(input match_rule_t r, input pkt_hdr_t h);
    logic [47:0] mac;
    logic [31:0] ip;
    logic [15:0] port;
    logic [15:0] pMax;
    logic [15:0] pMin;
    logic        macEq;
    logic        typEq;
    logic        flagOk;
    logic        portOk;
    logic        raw;
    logic        ok;
    mac   = r.ctrl.srcSel ? h.srcMac : h.dstMac;  // see [R9]
    ip    = r.ctrl.srcSel ? h.srcIp : h.dstIp;
    port  = r.ctrl.srcSel ? h.srcPort : h.dstPort;
    pMax  = r.valA[31:16];
    pMin  = r.valA[15:0];
    macEq = mac == {r.valB[15:0], r.valA};  // see [R11]
    typEq = h.etherType == r.valB[31:16];  // see [R11]
    flagOk = !r.ctrl.flagEn || ((h.tcpFlags ^ r.valB[15:8]) & ~r.valB[7:0]) == 8'h00;
    case (r.ctrl.portCmp)
      PC_OFF:     portOk = 1'b1;
      PC_EITHER:  portOk = port == pMax || port == pMin;
      PC_INSIDE:  portOk = port >= pMin && port <= pMax;
      PC_OUTSIDE: portOk = port < pMin || port > pMax;
      default:    portOk = 1'b0;
    endcase
    ok  = 1'b1;
    raw = 1'b0;
    case (r.ctrl.matchLayerSel)
      LAYER_L2:
      begin
        case (r.ctrl.matchOptionSel)  // see [R6]
          OPT_1:   raw = typEq;
          OPT_2:   raw = macEq;
          default: raw = macEq && typEq;
        endcase
      end
      LAYER_L3:
      begin
        ok = h.isIpv4;
        case (r.ctrl.matchOptionSel)  // see [R7]
          OPT_1:   raw = ((ip ^ r.valA) & ~r.valB) == 32'h0000_0000;
          OPT_2:   raw = h.srcIp == r.valA && h.dstIp == r.valB;
          default: ok = 1'b0;
        endcase
      end
      LAYER_L4:
      begin
        case (r.ctrl.matchOptionSel)  // see [R8]
          OPT_0:
          begin
            ok  = h.isIpv4;
            raw = h.protocol == r.ctrl.protocol;
          end
          OPT_1:
          begin
            ok  = h.isTcp;
            raw = portOk && flagOk;
          end
          OPT_2:
          begin
            ok  = h.isUdp;
            raw = portOk;
          end
          default:
          begin
            ok  = h.isTcp;
            raw = h.tcpSeq == r.valA && flagOk;
          end
        endcase
      end
      default: ok = 1'b0;  // see [R5]
    endcase
    return ok && (r.ctrl.matchPolarity ? raw : !raw);  // see [R10]
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic [1:0]           region;
    logic [IDX_W-1:0]     ent;
    logic [1:0]           word;
    logic [NUM_RULES-1:0] res;
    logic [NUM_RULES-1:0] cntRule;
    logic [NUM_RULES-1:0] cand;
    logic                 found;
    region  = wb_adr_i[REGION_LSB +: 2];
    ent     = wb_adr_i[ENTRY_LSB +: IDX_W];
    word    = wb_adr_i[WORD_LSB +: 2];
    res     = '0;
    cntRule = '0;
    cand    = '0;
    found   = 1'b0;
    st_next = st_reg;
    st_next.ack      = 1'b0;
    st_next.decValid = 1'b0;
    st_next.cntHit   = '0;
    st_next.usTick   = 1'b0;
    st_next.msTick   = 1'b0;

    // Time base shared by all count units
    if (st_reg.usCnt == US_CNT_W'(CYC_PER_US - 1))
    begin
      st_next.usCnt  = '0;
      st_next.usTick = 1'b1;
      if (st_reg.msCnt == MS_CNT_W'(US_PER_MS - 1))
      begin
        st_next.msCnt  = '0;
        st_next.msTick = 1'b1;
      end
      else
        st_next.msCnt = MS_CNT_W'(st_reg.msCnt + 1'b1);
    end
    else
      st_next.usCnt = US_CNT_W'(st_reg.usCnt + 1'b1);

    // Register access, one wait state, unmapped words read zero
    if (wb_cyc_i && wb_stb_i && !st_reg.ack)
    begin
      st_next.ack   = 1'b1;
      st_next.rdata = '0;
      case (region)
        REGION_MATCH:
        begin
          case (word)
            WORD_CTRL: st_next.rdata = st_reg.mrule[ent].ctrl;
            WORD_VALA: st_next.rdata = st_reg.mrule[ent].valA;
            WORD_VALB: st_next.rdata = st_reg.mrule[ent].valB;
            default:   st_next.rdata = '0;
          endcase
          if (wb_we_i)
          begin
            case (word)
              WORD_CTRL: st_next.mrule[ent].ctrl = mergeBytes(st_reg.mrule[ent].ctrl,
                           wb_dat_i, wb_sel_i, CTRL_WR_MASK);
              WORD_VALA: st_next.mrule[ent].valA = mergeBytes(st_reg.mrule[ent].valA,
                           wb_dat_i, wb_sel_i, '1);
              WORD_VALB: st_next.mrule[ent].valB = mergeBytes(st_reg.mrule[ent].valB,
                           wb_dat_i, wb_sel_i, '1);
              default: ;
            endcase
          end
        end
        REGION_ACTION:
        begin
          if (word == WORD_CTRL)
          begin
            st_next.rdata = st_reg.arule[ent];
            if (wb_we_i)
              st_next.arule[ent] = mergeBytes(st_reg.arule[ent], wb_dat_i, wb_sel_i,
                                              ACT_WR_MASK);
          end
        end
        REGION_PROC:
        begin
          if (word == WORD_CTRL)
          begin
            st_next.rdata = st_reg.pent[ent];
            if (wb_we_i)
              st_next.pent[ent] = mergeBytes(st_reg.pent[ent], wb_dat_i, wb_sel_i,
                                             PROC_WR_MASK);
          end
        end
        default:
        begin
          if (ent == STAT_ENTRY && word == WORD_CTRL)
            st_next.rdata = {{(32 - IDX_W - 1){1'b0}}, st_reg.hit, st_reg.idx};
        end
      endcase
    end

    // Evaluate every matching rule on every packet
    for (int i = 0; i < NUM_RULES; i++)
    begin
      cntRule[i] = isCountRule(st_reg.mrule[i]);
      res[i]     = evalRule(st_reg.mrule[i], pktHdr);  // see [R17]
    end
    if (pktValid)
      st_next.cntHit = res & cntRule;

    // Count rules and their dedicated actions never forward
    for (int e = 0; e < NUM_RULES; e++)
    begin
      if (st_reg.pent[e].ruleSelectMask != 16'h0000 &&
          (st_reg.pent[e].ruleSelectMask & ~(res & ~cntRule)) == 16'h0000)  // see [R2] [R16]
        cand[st_reg.pent[e].actionPointer] = 1'b1;  // see [R1] [R4]
    end
    cand = cand & ~cntRule;  // see [R16]

    if (pktValid)
    begin
      st_next.decValid = 1'b1;  // see [R19]
      st_next.hit      = 1'b0;
      st_next.idx      = '0;
      st_next.act      = '0;
      for (int a = 0; a < NUM_RULES; a++)
      begin
        if (cand[a] && !found)
        begin
          found       = 1'b1;
          st_next.hit = 1'b1;  // see [R3]
          st_next.idx = IDX_W'(a);
          st_next.act = st_reg.arule[a];
        end
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  // ****************************************
  // Count units
  // ****************************************
  for (genvar g = 0; g < NUM_RULES; g++)
  begin : gCount
    acl_count_unit uCount (
      .mclk       (mclk),
      .rst        (rst),
      .usTick     (st_reg.usTick),
      .msTick     (st_reg.msTick),
      .enable     (isCountRule(st_reg.mrule[g])),
      .algorithm  (st_reg.arule[g].countAlgorithm),
      .timeUnit   (st_reg.arule[g].countTimeUnit),
      .countValue ({st_reg.arule[g].priorityModeField,  // see [R12]
                    st_reg.arule[g].priorityValue,
                    st_reg.arule[g].remarkEnableField,
                    st_reg.arule[g].remarkValueField,
                    st_reg.arule[g].mapModeField}),
      .hit        (st_reg.cntHit[g]),
      .expire     (countIrq[g])
    );
  end

  assign wb_dat_o      = st_reg.rdata;
  assign wb_ack_o      = st_reg.ack;
  assign decisionValid = st_reg.decValid;
  assign actionHit     = st_reg.hit;
  assign actionIndex   = st_reg.idx;
  assign actionRule    = st_reg.act;
endmodule

// *** testbench/acl_rule_evaluator_monitor.sv ***
// Port checker for the ACL evaluator: bus handshake and decision timing.
// Assumes one clock domain; bound to every evaluator instance.
`timescale 1ns/10ps
module acl_rule_evaluator_monitor
  import acl_pkg::*;
(
  // Clock and reset
  input wire logic             mclk,
  input wire logic             rst,
  // Register bus
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic             wb_we_i,
  input wire logic             wb_cyc_i,
  input wire logic             wb_stb_i,
  input wire logic [31:0]      wb_dat_o,
  input wire logic             wb_ack_o,
  // Packet path
  input wire logic             pktValid,
  input wire logic             decisionValid,
  input wire logic             actionHit,
  input wire logic [IDX_W-1:0] actionIndex,
  input wire action_rule_t     actionRule
);
  logic takenNow;

  assign takenNow = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence taken_s;
    takenNow;
  endsequence

  sequence ack_once_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence

  chk_bus_answer: assert property (taken_s |=> ack_once_s)
    else $error("bus request not answered by a single ack");
  chk_ack_cause: assert property (wb_ack_o |-> $past(takenNow))
    else $error("ack without a taken request");
  chk_rdata_hold: assert property (!$past(rst) && !takenNow |=> $stable(wb_dat_o))
    else $error("read data moved without a request");
  chk_decision_follow: assert property (pktValid |=> decisionValid)
    else $error("no decision one cycle after a packet");
  chk_decision_cause: assert property (decisionValid |-> $past(pktValid))
    else $error("decision without a packet");
  chk_miss_zero: assert property (
    decisionValid && !actionHit |-> actionIndex == 4'h0 && actionRule == action_rule_t'(32'h0))
    else $error("miss carries a stale action");
  chk_result_hold: assert property (
    !$past(rst) && !decisionValid |-> $stable(actionHit) && $stable(actionIndex)
    && $stable(actionRule))
    else $error("decision outputs moved between packets");
  chk_status_read: assert property (
    takenNow && !wb_we_i && wb_adr_i == 10'h300 && !pktValid && !decisionValid
    |=> wb_dat_o == {27'h0, $past(actionHit), $past(actionIndex)})
    else $error("status read disagrees with last decision");
endmodule

bind acl_rule_evaluator acl_rule_evaluator_monitor mon (.mclk, .rst, .wb_adr_i, .wb_we_i,
  .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .pktValid, .decisionValid, .actionHit,
  .actionIndex, .actionRule);

// *** testbench/hdr_source.sv ***
// Header parser stand-in: one packet pulse for each bench request.
// Assumes sendReq is raised for one cycle per packet.
`timescale 1ns/10ps
module hdr_source
  import acl_pkg::*;
(
  // Clock
  input  wire logic mclk,
  // Bench side
  input  wire logic sendReq,
  input  pkt_hdr_t  reqHdr,
  // Evaluator side
  output logic      pktValid,
  output pkt_hdr_t  pktHdr
);
  initial
  begin
    pktValid = 1'b0;
    pktHdr = '0;
  end

  // Scramble the header outside the pulse so stale fields cannot match in the cycle after it
  always @(posedge mclk)
  begin
    pktValid <= sendReq;
    pktHdr <= sendReq ? reqHdr : ~pktHdr;
  end
endmodule

// *** testbench/tb.sv ***
// Bench: random tables and packets against a behavioural model, then count modes.
// Assumes the evaluator's register map and its one-cycle bus and decision latencies.
`timescale 1ns/10ps
module tb
  import acl_pkg::*;
();
  logic         mclk, rst, wbWe, wbCyc, wbStb, wbAck, sendReq, pktValid;
  logic         decisionValid, actionHit;
  logic [9:0]   wbAdr;
  logic [31:0]  wbDatI, wbDatO, rd, ra, rb;
  logic [3:0]   wbSel, actionIndex;
  logic [15:0]  countIrq, irqNow;
  logic [4:0]   lastW;
  pkt_hdr_t     reqHdr, pktHdr, h;
  action_rule_t actionRule;
  match_ctrl_t  c;
  logic [31:0]  mc[16], ma[16], mb[16], ac[16], pe[16];
  logic [47:0]  macs[2] = '{48'h0011_2233_4455, 48'hA0B1_C2D3_E4F5};
  logic [15:0]  ets[2] = '{16'h0800, 16'h88F7};
  logic [31:0]  ips[2] = '{32'h0A00_0001, 32'h0A00_0002};
  int           err_total, n_checks, cycles, irqCnt, i, k, base;

  acl_rule_evaluator DUT (.mclk, .rst, .wb_adr_i(wbAdr), .wb_dat_i(wbDatI), .wb_sel_i(wbSel),
    .wb_we_i(wbWe), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .pktValid, .pktHdr, .decisionValid, .actionHit, .actionIndex, .actionRule, .countIrq);
  hdr_source src (.mclk, .sendReq, .reqHdr, .pktValid, .pktHdr);

  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Cycle ceiling, and a running count of watchdog pulses from rule 1
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    irqCnt <= irqCnt + int'(countIrq[1]);
    if (cycles == 20000)
    begin
      err_total = err_total + 1;
      close_out();
    end
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] want, input string what);
    n_checks++;
    if (seen !== want)
    begin
      err_total++;
      $display("wrong value at %0t: %s seen %h want %h", $time, what, seen, want);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wb(input logic we, input logic [9:0] adr, input logic [31:0] d,
                    input logic [3:0] sel, output logic [31:0] q);
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= d;
    wbSel <= sel;
    do @(posedge mclk); while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic wr(input logic [9:0] adr, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, adr, d, 4'hF, q);
  endtask

  function automatic logic [9:0] adrOf(input logic [1:0] rg, input int e, input logic [1:0] w);
    return {rg, 4'(e), w, 2'h0};
  endfunction

  task automatic prog(input int e, input logic [31:0] ct, a, b, act, p);
    mc[e] = ct & CTRL_WR_MASK;
    ma[e] = a;
    mb[e] = b;
    ac[e] = act & ACT_WR_MASK;
    pe[e] = p & PROC_WR_MASK;
    wr(adrOf(REGION_MATCH, e, WORD_CTRL), ct);
    wr(adrOf(REGION_MATCH, e, WORD_VALA), a);
    wr(adrOf(REGION_MATCH, e, WORD_VALB), b);
    wr(adrOf(REGION_ACTION, e, WORD_CTRL), act);
    wr(adrOf(REGION_PROC, e, WORD_CTRL), p);
  endtask

  function automatic logic ruleTrue(input int i, input pkt_hdr_t p);
    match_ctrl_t t;
    logic [47:0] mac;
    logic [31:0] ip;
    logic        eq;
    logic        need;
    logic [15:0] pt;
    t = match_ctrl_t'(mc[i]);
    mac = t.srcSel ? p.srcMac : p.dstMac;
    ip = t.srcSel ? p.srcIp : p.dstIp;
    pt = t.srcSel ? p.srcPort : p.dstPort;
    need = t.matchLayerSel == LAYER_L2 || p.isIpv4;
    eq = pt == ma[i][31:16] || pt == ma[i][15:0];
    case ({t.matchLayerSel, t.matchOptionSel})
      4'h5: eq = p.etherType == mb[i][31:16];
      4'h6: eq = mac == {mb[i][15:0], ma[i]};
      4'h7: eq = mac == {mb[i][15:0], ma[i]} && p.etherType == mb[i][31:16];
      4'h9: eq = ((ip ^ ma[i]) & ~mb[i]) == 32'h0;
      4'hA: eq = p.srcIp == ma[i] && p.dstIp == mb[i];
      4'hC: eq = p.protocol == t.protocol;
      4'hD: need = p.isTcp;
      4'hE: need = p.isUdp;
      4'hF: {need, eq} = {p.isTcp, p.tcpSeq == ma[i]};
      default: return 1'b0;
    endcase
    if (!need)
      return 1'b0;
    return t.matchPolarity ? eq : !eq;
  endfunction

  function automatic logic [4:0] decide(input pkt_hdr_t p);
    logic [15:0] cand;
    logic        all;
    cand = 16'h0;
    for (int e = 0; e < 16; e++)
    begin
      all = pe[e][15:0] != 16'h0;
      for (int m = 0; m < 16; m++)
        if (pe[e][m] && !ruleTrue(m, p))
          all = 1'b0;
      if (all && mc[pe[e][19:16]][3:0] != 4'h1)
        cand[pe[e][19:16]] = 1'b1;
    end
    for (int j = 0; j < 16; j++)
      if (cand[j])
        return {1'b1, 4'(j)};
    return 5'h0;
  endfunction

  task automatic send(input pkt_hdr_t p);
    lastW = decide(p);
    @(posedge mclk);
    sendReq <= 1'b1;
    reqHdr <= p;
    @(posedge mclk);
    sendReq <= 1'b0;
    @(posedge mclk);
    #1;
    check(decisionValid, 1'b1, "decision strobe");
    check({actionHit, actionIndex}, lastW, "chosen action");
    check(actionRule, lastW[4] ? ac[lastW[3:0]] : 32'h0, "action contents");
    @(posedge mclk);
    #1;
    irqNow = countIrq;
  endtask

  initial
  begin
    rst = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 10'h0;
    wbDatI = 32'h0;
    wbSel = 4'h0;
    sendReq = 1'b0;
    reqHdr = '0;
    h = '0;
    k = $urandom(32'h5AA233C8);
    for (i = 0; i < 16; i++)
      {mc[i], ma[i], mb[i], ac[i], pe[i]} = 160'h0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    wb(1'b0, adrOf(REGION_PROC, 5, WORD_CTRL), 32'h0, 4'hF, rd);
    check(rd, 32'h0, "processing reset value");
    wb(1'b0, 10'h300, 32'h0, 4'hF, rd);
    check(rd, 32'h0, "status reset value");
    wr(10'h00C, 32'hFFFF_FFFF);
    wb(1'b0, 10'h00C, 32'h0, 4'hF, rd);
    check(rd, 32'h0, "unmapped word");
    wb(1'b1, adrOf(REGION_ACTION, 3, WORD_CTRL), 32'hFFFF_FFFF, 4'h2, rd);
    wb(1'b0, adrOf(REGION_ACTION, 3, WORD_CTRL), 32'h0, 4'hF, rd);
    check(rd, ACT_WR_MASK & 32'h0000_FF00, "byte lane write");
    // Random tables: small value pools so that hits and misses both occur
    repeat (6)
    begin
      for (i = 0; i < 16; i++)
      begin
        k = $urandom_range(0, 1);
        c = match_ctrl_t'($urandom & 32'h3F);
        c.protocol = k ? 8'h06 : 8'h11;
        if (c.matchLayerSel == LAYER_L4)
          c.portCmp = PC_EITHER;
        ra = c.matchLayerSel == LAYER_L2 ? macs[k][31:0] : ips[k];
        rb = c.matchLayerSel == LAYER_L2 ? {ets[k], macs[k][47:32]} : ips[$urandom_range(0, 1)];
        if (c.matchOptionSel == OPT_1 && c.matchLayerSel == LAYER_L3)
          rb = $urandom & 32'h3;
        prog(i, c, ra, rb, $urandom, {12'h0, 4'($urandom), 16'h1 << $urandom_range(0, 15)
             | 16'h1 << $urandom_range(0, 15)});
      end
      repeat (30)
      begin
        k = $urandom_range(0, 1);
        h.dstMac = macs[k];
        h.srcMac = macs[$urandom_range(0, 1)];
        h.etherType = ets[$urandom_range(0, 1)];
        h.isIpv4 = 1'($urandom);
        h.srcIp = ips[k];
        h.dstIp = ips[$urandom_range(0, 1)];
        h.protocol = k ? 8'h06 : 8'h11;
        {h.isTcp, h.isUdp} = 2'($urandom);
        h.srcPort = 16'(k + 1);
        h.dstPort = 16'($urandom_range(1, 2));
        h.tcpSeq = h.dstIp;
        send(h);
      end
      wb(1'b0, 10'h300, 32'h0, 4'hF, rd);
      check(rd, {27'h0, lastW}, "status word");
    end
    for (i = 0; i < 16; i++)
      prog(i, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0);
    // Event counter on rule 0, terminal count 3, also pointed at by entry 0
    prog(0, 32'h21, macs[0][31:0], {ets[0], macs[0][47:32]}, 32'h1003, 32'h1);
    h.dstMac = macs[0];
    h.etherType = ets[0];
    for (i = 1; i <= 4; i++)
    begin
      send(h);
      check(irqNow, i == 3 ? 16'h1 : 16'h0, "event count pulse");
    end
    // Watchdog on rule 1, source address, two microsecond units
    prog(1, 32'h31, macs[1][31:0], {ets[1], macs[1][47:32]}, 32'h2, 32'h0);
    h.srcMac = macs[1];
    h.etherType = ets[1];
    send(h);
    repeat (3) @(posedge mclk);
    base = irqCnt;
    repeat (6)
    begin
      repeat (40) @(posedge mclk);
      send(h);
    end
    check(32'(irqCnt - base), 32'h0, "watchdog kept fed");
    base = irqCnt;
    repeat (250) @(posedge mclk);
    check(32'(irqCnt - base), 32'h1, "watchdog expiry");
    close_out();
  end
endmodule
